// File: include/iom_pkg.sv
package iom_pkg;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 6;
  localparam int REG_W     = 16;
  localparam int DIGIT_W   = 4;
  localparam int SRC_NUM   = 10;
  localparam int PORT_NUM  = 6;
  localparam int INPUT_NUM = 8;
  localparam int LVL_PINS  = 4;
  localparam int FILT_W    = 10;
  localparam int ALM_W     = 2;

  localparam logic [ADDR_W-1:0] OFS_ROUTE_A = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_B = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_C = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_IN_FILT = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_AL_FILT = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_A = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_B = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 6'h20;

  localparam logic [REG_W-1:0] RST_ROUTE_A = 16'h4321;
  localparam logic [REG_W-1:0] RST_ROUTE_B = 16'h0065;
  localparam logic [REG_W-1:0] RST_ROUTE_C = 16'h0000;
  localparam logic [REG_W-1:0] RST_IN_FILT = 16'h0001;
  localparam logic [REG_W-1:0] RST_AL_FILT = 16'h0001;
  localparam logic [REG_W-1:0] RST_LEVEL   = 16'h0000;
  localparam logic [REG_W-1:0] MAX_IN_FILT = 16'h03E8;
  localparam logic [REG_W-1:0] MAX_AL_FILT = 16'h0003;

  localparam int CTRL_RESTART_BIT = 0;
  localparam int STAT_ALARM_BIT   = 8;
  localparam int STAT_PEND_BIT    = 16;

  localparam int SRC_ALARM   = 0;
  localparam int SRC_POSCMP  = 1;
  localparam int SRC_ROTATE  = 2;
  localparam int SRC_READY   = 3;
  localparam int SRC_BRAKE   = 4;
  localparam int SRC_ORIGIN  = 5;
  localparam int SRC_INPOS0  = 6;

  localparam logic PIN_IDLE = 1'b1;

  localparam int CLK_PERIOD_NS = 40;
  localparam int FILT_STEP_NS  = 100000;
  localparam int STEP_CYCLES   = FILT_STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W    = 12;
endpackage

// File: logic/iom_step_tick.sv
`timescale 1ns/10ps
`default_nettype none
module iom_step_tick
  import iom_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick
);
  logic [STEP_CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg == STEP_CNT_W'(STEP_CYCLES - 1)) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_reg == STEP_CNT_W'(STEP_CYCLES - 1));
    end
  end
endmodule
`default_nettype wire

// File: logic/iom_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module iom_debounce
  import iom_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic              raw,
  input  wire logic [FILT_W-1:0] steps,
  output logic                   filt
);
  logic [FILT_W-1:0] cnt_reg;

  // Level must stay different for the full step count before it is taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      filt    <= PIN_IDLE;
    end else if (raw == filt) begin
      cnt_reg <= '0;
    end else if (steps == '0) begin
      filt    <= raw;
    end else if (tick) begin
      if (cnt_reg + 1'b1 >= steps) begin
        filt    <= raw;
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: logic/iom_io_map.sv
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module iom_io_map
  import iom_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [DATA_W-1:0]      avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              alarm_flag,
  input  wire logic              position_complete_flag,
  input  wire logic              rotation_detect_flag,
  input  wire logic              servo_ready_flag,
  input  wire logic              brake_flag,
  input  wire logic              encoder_origin_flag,
  input  wire logic              internal_pos_mode,
  input  wire logic              inpos_set_bit_zero,
  input  wire logic              inpos_set_bit_one,
  input  wire logic              inpos_set_bit_two,
  input  wire logic              inpos_set_bit_three,
  input  wire logic [INPUT_NUM-1:0] input_pin,
  input  wire logic              alarm_pin,
  output logic                   output_port_one,
  output logic                   output_port_two,
  output logic                   output_port_three,
  output logic                   output_port_four,
  output logic                   output_port_five,
  output logic                   output_port_six,
  output logic [INPUT_NUM-1:0]   input_active,
  output logic                   alarm_input_active
);
  logic [REG_W-1:0]         route_a_reg;
  logic [REG_W-1:0]         route_b_reg;
  logic [REG_W-1:0]         route_c_reg;
  logic [REG_W-1:0]         act_a_reg;
  logic [REG_W-1:0]         act_b_reg;
  logic [REG_W-1:0]         act_c_reg;
  logic [REG_W-1:0]         in_filt_reg;
  logic [REG_W-1:0]         al_filt_reg;
  logic [REG_W-1:0]         level_a_reg;
  logic [REG_W-1:0]         level_b_reg;
  logic [REG_W-1:0]         wr_merged;
  logic [PORT_NUM-1:0]      port_next;
  logic [PORT_NUM-1:0]      port_reg;
  logic [SRC_NUM-1:0]       src;
  logic [SRC_NUM*DIGIT_W-1:0] digits;
  logic [INPUT_NUM-1:0]     pin_filt;
  logic [INPUT_NUM-1:0]     level_sel;
  logic                     alarm_filt;
  logic                     tick;
  logic                     wr_fire;
  logic                     rd_take;
  logic                     restart;
  logic                     pending;

  // Bus handshake
  // Every access is answered with exactly one low cycle of waitrequest
  assign wr_fire = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && avs_waitrequest;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Only the two low byte lanes carry writable register bits
  always_comb begin
    wr_merged = '0;
    case (avs_address)
      OFS_ROUTE_A: wr_merged = route_a_reg;
      OFS_ROUTE_B: wr_merged = route_b_reg;
      OFS_ROUTE_C: wr_merged = route_c_reg;
      OFS_IN_FILT: wr_merged = in_filt_reg;
      OFS_AL_FILT: wr_merged = al_filt_reg;
      OFS_LEVEL_A: wr_merged = level_a_reg;
      OFS_LEVEL_B: wr_merged = level_b_reg;
      default:     wr_merged = '0;
    endcase
    if (avs_byteenable[0]) begin
      wr_merged[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1]) begin
      wr_merged[15:8] = avs_writedata[15:8];
    end
  end

  assign restart = wr_fire && avs_address == OFS_CONTROL &&
                   avs_byteenable[0] && avs_writedata[CTRL_RESTART_BIT];
  assign pending = {route_a_reg, route_b_reg, route_c_reg} !=
                   {act_a_reg, act_b_reg, act_c_reg};

  // Pending routing, written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      route_a_reg <= RST_ROUTE_A;
      route_b_reg <= RST_ROUTE_B;
      route_c_reg <= RST_ROUTE_C;
    end else if (wr_fire) begin
      if (avs_address == OFS_ROUTE_A) begin
        route_a_reg <= wr_merged;
      end
      if (avs_address == OFS_ROUTE_B) begin
        route_b_reg <= wr_merged;
      end
      if (avs_address == OFS_ROUTE_C) begin
        route_c_reg <= wr_merged;
      end
    end
  end

  // Routing in force; a restart stands in for the power cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_a_reg <= RST_ROUTE_A;
      act_b_reg <= RST_ROUTE_B;
      act_c_reg <= RST_ROUTE_C;
    end else if (restart) begin
      act_a_reg <= route_a_reg;
      act_b_reg <= route_b_reg;
      act_c_reg <= route_c_reg;
    end
  end

  // Filter and level settings act immediately
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_filt_reg <= RST_IN_FILT;
      al_filt_reg <= RST_AL_FILT;
      level_a_reg <= RST_LEVEL;
      level_b_reg <= RST_LEVEL;
    end else if (wr_fire) begin
      // Out-of-range times clamp rather than wrap
      if (avs_address == OFS_IN_FILT) begin
        in_filt_reg <= (wr_merged > MAX_IN_FILT) ? MAX_IN_FILT
                                                 : wr_merged;
      end
      if (avs_address == OFS_AL_FILT) begin
        al_filt_reg <= (wr_merged > MAX_AL_FILT) ? MAX_AL_FILT
                                                 : wr_merged;
      end
      if (avs_address == OFS_LEVEL_A) begin
        level_a_reg <= wr_merged;
      end
      if (avs_address == OFS_LEVEL_B) begin
        level_b_reg <= wr_merged;
      end
    end
  end

  // Read data stands when waitrequest drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= '0;
    end else if (rd_take) begin
      unique case (avs_address)
        OFS_ROUTE_A: avs_readdata <= DATA_W'(route_a_reg);
        OFS_ROUTE_B: avs_readdata <= DATA_W'(route_b_reg);
        OFS_ROUTE_C: avs_readdata <= DATA_W'(route_c_reg);
        OFS_IN_FILT: avs_readdata <= DATA_W'(in_filt_reg);
        OFS_AL_FILT: avs_readdata <= DATA_W'(al_filt_reg);
        OFS_LEVEL_A: avs_readdata <= DATA_W'(level_a_reg);
        OFS_LEVEL_B: avs_readdata <= DATA_W'(level_b_reg);
        OFS_STATUS: begin
          avs_readdata <= '0;
          avs_readdata[INPUT_NUM-1:0]  <= input_active;
          avs_readdata[STAT_ALARM_BIT] <= alarm_input_active;
          avs_readdata[STAT_PEND_BIT]  <= pending;
        end
        default:     avs_readdata <= '0;
      endcase
    end
  end

  // Output routing
  // Set-number bits only count in internal position mode
  assign src = {inpos_set_bit_three && internal_pos_mode,
                inpos_set_bit_two && internal_pos_mode,
                inpos_set_bit_one && internal_pos_mode,
                inpos_set_bit_zero && internal_pos_mode,
                encoder_origin_flag, brake_flag, servo_ready_flag,
                rotation_detect_flag, position_complete_flag, alarm_flag};
  assign digits = {act_c_reg, act_b_reg[2*DIGIT_W-1:0], act_a_reg};

  // Two signals on one port are OR-ed; digits 7 to 15 drive nothing
  generate
    for (genvar p = 0; p < PORT_NUM; p++) begin : g_port
      logic [SRC_NUM-1:0] hit;
      for (genvar s = 0; s < SRC_NUM; s++) begin : g_src
        assign hit[s] = src[s] &&
          digits[s*DIGIT_W +: DIGIT_W] == DIGIT_W'(p + 1);
      end
      assign port_next[p] = |hit;
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_reg <= '0;
    end else begin
      port_reg <= port_next;
    end
  end

  assign output_port_one   = port_reg[0];
  assign output_port_two   = port_reg[1];
  assign output_port_three = port_reg[2];
  assign output_port_four  = port_reg[3];
  assign output_port_five  = port_reg[4];
  assign output_port_six   = port_reg[5];

  // Input filtering and level
  iom_step_tick u_tick (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  generate
    for (genvar i = 0; i < INPUT_NUM; i++) begin : g_in
      iom_debounce u_deb (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick),
        .raw     (input_pin[i]),
        .steps   (in_filt_reg[FILT_W-1:0]),
        .filt    (pin_filt[i])
      );
    end
  endgenerate

  iom_debounce u_alarm_deb (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick),
    .raw     (alarm_pin),
    .steps   (FILT_W'(al_filt_reg[ALM_W-1:0])),
    .filt    (alarm_filt)
  );

  assign level_sel = {level_b_reg[LVL_PINS-1:0],
                      level_a_reg[LVL_PINS-1:0]};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_active       <= '0;
      alarm_input_active <= 1'b0;
    end else begin
      // Low pin asserts for 0, high pin asserts for 1
      input_active       <= ~(pin_filt ^ level_sel);
      alarm_input_active <= alarm_filt;
    end
  end

  // Checks
  logic [PORT_NUM-1:0] ab_hit;
  logic [PORT_NUM-1:0] any_dig;

  generate
    for (genvar p = 0; p < PORT_NUM; p++) begin : g_chk
      assign ab_hit[p] = (g_port[p].hit[SRC_INPOS0-1:0] != '0);
      assign any_dig[p] =
        act_a_reg[SRC_ALARM*DIGIT_W +: DIGIT_W] == DIGIT_W'(p + 1) ||
        act_a_reg[SRC_READY*DIGIT_W +: DIGIT_W] == DIGIT_W'(p + 1);
    end
  endgenerate

  sequence s_request;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_one_low;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_waitreq_single_low: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    s_request |=> s_one_low)
    else $error("waitrequest not low for exactly one cycle");

  a_route_apply_copy: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    restart |=> act_a_reg == $past(route_a_reg) &&
                act_c_reg == $past(route_c_reg))
    else $error("restart did not load pending routing");

  a_route_hold_active: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !restart |=> $stable(act_a_reg) && $stable(act_b_reg))
    else $error("active routing changed without restart");

  a_alarm_port_map: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (alarm_flag && act_a_reg[DIGIT_W-1:0] == DIGIT_W'(1))
      |=> output_port_one)
    else $error("alarm not on port one");

  a_ready_zero_unused: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (act_a_reg[SRC_READY*DIGIT_W +: DIGIT_W] == '0 &&
     act_a_reg[3*DIGIT_W-1:0] == '0 && act_b_reg[2*DIGIT_W-1:0] == '0 &&
     !internal_pos_mode) |=> port_reg == '0)
    else $error("port driven with all routing disabled");

  a_inpos_mode_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!internal_pos_mode && !ab_hit[2]) |=> !output_port_three)
    else $error("set-number bit routed outside position mode");

  a_ready_port_map: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (servo_ready_flag && !any_dig[0] &&
     act_a_reg[SRC_READY*DIGIT_W +: DIGIT_W] == DIGIT_W'(4))
      |=> output_port_four)
    else $error("servo ready not on selected port");

  a_level_low_active: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!level_a_reg[0] && !pin_filt[0]) |=> input_active[0])
    else $error("low pin not asserted with level bit 0");

  a_level_high_active: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (level_b_reg[0] && pin_filt[LVL_PINS]) |=> input_active[LVL_PINS])
    else $error("high pin not asserted with level bit 1");

  a_filter_clamp_max: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_fire && avs_address == OFS_IN_FILT && wr_merged > MAX_IN_FILT)
      |=> in_filt_reg == MAX_IN_FILT)
    else $error("input filter time not clamped");
endmodule
`default_nettype wire

// File: bench/iom_field_model.sv
`timescale 1ns/10ps
`default_nettype none
module iom_field_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] pin_cmd,
  input  wire logic       alarm_cmd,
  output logic [7:0]      input_pin,
  output logic            alarm_pin
);
  // Contacts settle one cycle after the controller decides, never mid-cycle
  always_ff @(posedge clk_sys) begin
    input_pin <= pin_cmd;
    alarm_pin <= alarm_cmd;
  end
endmodule
`default_nettype wire

// File: bench/io_signal_mapping_test.sv
`timescale 1ns/10ps
`default_nettype none
module io_signal_mapping_test;
  import iom_pkg::*;
  logic              clk_sys;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  wire  [DATA_W-1:0] avs_readdata;
  wire               avs_waitrequest;
  logic [9:0]        src;
  logic              ipm;
  logic [7:0]        pin_cmd;
  logic              alarm_cmd;
  wire  [7:0]        input_pin;
  wire               alarm_pin;
  wire  [5:0]        ports;
  wire  [7:0]        input_active;
  wire               alarm_input_active;
  int                n_fail;
  int                checks_done;
  logic [15:0]       ra;
  logic [15:0]       rb;
  logic [15:0]       rc;
  logic [15:0]       la;
  logic [15:0]       lb;
  logic [31:0]       rd;
  logic              mode;
  logic [ADDR_W-1:0] ofs [7];
  logic [15:0]       rstv [7];

  iom_io_map iom_io_map_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .alarm_flag(src[0]), .position_complete_flag(src[1]),
    .rotation_detect_flag(src[2]), .servo_ready_flag(src[3]),
    .brake_flag(src[4]), .encoder_origin_flag(src[5]),
    .internal_pos_mode(ipm), .inpos_set_bit_zero(src[6]),
    .inpos_set_bit_one(src[7]), .inpos_set_bit_two(src[8]),
    .inpos_set_bit_three(src[9]), .input_pin(input_pin),
    .alarm_pin(alarm_pin), .output_port_one(ports[0]),
    .output_port_two(ports[1]), .output_port_three(ports[2]),
    .output_port_four(ports[3]), .output_port_five(ports[4]),
    .output_port_six(ports[5]), .input_active(input_active),
    .alarm_input_active(alarm_input_active)
  );

  iom_field_model iom_field_model_i (
    .clk_sys(clk_sys), .pin_cmd(pin_cmd), .alarm_cmd(alarm_cmd),
    .input_pin(input_pin), .alarm_pin(alarm_pin)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_vec(input string nm, input logic [7:0] e,
                         input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bus_wait();
    int k;
    for (k = 0; k < 100; k++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 100) begin
      n_fail++;
      $display("wrong value handshake expected done seen timeout");
      end_sim();
    end
  endtask

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  function automatic logic [7:0] exp_ports(input logic [15:0] a, b, c,
                                           input logic [9:0] s,
                                           input logic m);
    logic [7:0] p;
    logic [3:0] d;
    p = 8'h00;
    for (int i = 0; i < 10; i++) begin
      d = i < 4 ? a[i*4+:4] : i < 6 ? b[(i-4)*4+:4] : c[(i-6)*4+:4];
      // Set-number bits only count in internal position mode
      if (s[i] && (i < 6 || m) && d >= 4'h1 && d <= 4'h6) p[d-1] = 1'b1;
    end
    return p;
  endfunction

  function automatic logic [15:0] rnd_route();
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[i*4+:4] = 4'($urandom_range(6, 0));
    return r;
  endfunction

  // Level bit 0 asserts on a low pin, level bit 1 on a high pin
  function automatic logic [7:0] exp_active(input logic [7:0] pin, lvl);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = lvl[i] ? pin[i] : !pin[i];
    return r;
  endfunction

  task automatic chk_route(input logic [9:0] s, input logic m);
    src <= s;
    ipm <= m;
    wait_cyc(3);
    chk_vec("ports", exp_ports(ra, rb, rc, s, m), {2'b00, ports});
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    src = '0;
    ipm = 1'b0;
    pin_cmd = 8'h00;
    alarm_cmd = 1'b0;
    n_fail = 0;
    checks_done = 0;
    rd = $urandom(32'h2503e83f);
    ofs = '{OFS_ROUTE_A, OFS_ROUTE_B, OFS_ROUTE_C, OFS_IN_FILT,
            OFS_AL_FILT, OFS_LEVEL_A, OFS_LEVEL_B};
    rstv = '{16'h4321, 16'h0065, 16'h0000, 16'h0001, 16'h0001,
             16'h0000, 16'h0000};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus_rd(ofs[i], rd);
      chk_reg("reset", 32'(rstv[i]), rd);
    end
    bus_rd(6'h24, rd);
    chk_reg("unmapped read", 32'h0000_0000, rd);
    $display("test reset values done");

    ra = 16'h4321;
    rb = 16'h0065;
    rc = 16'h0000;
    for (int i = 0; i < 10; i++) begin
      chk_route(10'($urandom), 1'b1);
    end
    $display("test factory routing done");

    // Pending routes must not steer ports until restart
    la = rnd_route();
    lb = rnd_route() & 16'h00FF;
    rd = {16'h0000, rnd_route()};
    bus_wr(OFS_ROUTE_A, la);
    bus_wr(OFS_ROUTE_B, lb);
    bus_wr(OFS_ROUTE_C, rd[15:0]);
    chk_route(10'h3FF, 1'b1);
    bus_wr(OFS_CONTROL, 16'h0001);
    ra = la;
    rb = lb;
    rc = rd[15:0];
    chk_route(10'h3FF, 1'b1);
    chk_route(10'h3FF, 1'b0);
    for (int j = 0; j < 12; j++) begin
      // Pass one idles every digit of A and B, so all ports must stay low
      ra = j == 1 ? 16'h0000 : rnd_route();
      rb = j == 1 ? 16'h0000 : rnd_route() & 16'h00FF;
      rc = j == 0 ? 16'h0000 : rnd_route();
      bus_wr(OFS_ROUTE_A, ra);
      bus_wr(OFS_ROUTE_B, rb);
      bus_wr(OFS_ROUTE_C, rc);
      bus_wr(OFS_CONTROL, 16'h0001);
      bus_rd(OFS_ROUTE_A, rd);
      chk_reg("route a", {16'h0000, ra}, rd);
      for (int i = 0; i < 4; i++) begin
        mode = j == 1 ? 1'b0 : 1'($urandom);
        chk_route(10'($urandom), mode);
      end
    end
    $display("test routing done");

    bus_wr(OFS_IN_FILT, 16'h0000);
    bus_wr(OFS_AL_FILT, 16'h0000);
    for (int j = 0; j < 10; j++) begin
      la = {12'h000, 4'($urandom)};
      lb = {12'h000, 4'($urandom)};
      bus_wr(OFS_LEVEL_A, la);
      bus_wr(OFS_LEVEL_B, lb);
      pin_cmd <= 8'($urandom);
      alarm_cmd <= 1'($urandom);
      wait_cyc(6);
      chk_vec("input active", exp_active(pin_cmd, {lb[3:0], la[3:0]}),
              input_active);
      chk_vec("alarm active", {7'h00, alarm_cmd},
              {7'h00, alarm_input_active});
    end
    $display("test input level done");

    bus_wr(OFS_IN_FILT, 16'h05DC);
    bus_rd(OFS_IN_FILT, rd);
    chk_reg("input filter clamp", 32'h0000_03E8, rd);
    bus_wr(OFS_AL_FILT, 16'h0005);
    bus_rd(OFS_AL_FILT, rd);
    chk_reg("alarm filter clamp", 32'h0000_0003, rd);
    bus_wr(OFS_IN_FILT, 16'h0002);
    bus_wr(OFS_LEVEL_A, 16'h000F);
    bus_wr(OFS_LEVEL_B, 16'h000F);
    pin_cmd <= 8'h00;
    alarm_cmd <= 1'b0;
    wait_cyc(10100);
    chk_vec("input settled", 8'h00, input_active);
    pin_cmd <= 8'hFF;
    alarm_cmd <= 1'b1;
    // First tick may be partial, so allow one step less
    wait_cyc(2480);
    chk_vec("input early", 8'h00, input_active);
    wait_cyc(2500);
    chk_vec("alarm early", 8'h00, {7'h00, alarm_input_active});
    wait_cyc(40);
    chk_vec("input filtered", 8'hFF, input_active);
    wait_cyc(2500);
    chk_vec("alarm filtered", 8'h01, {7'h00, alarm_input_active});
    $display("test filter timing done");
    end_sim();
  end
endmodule
`default_nettype wire
